/* File: pwt_pkg.sv */
package pwt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // channel counts
    localparam int PWT_POS_CHANNELS = 4;
    localparam int PWT_ROT_CHANNELS = 4;
    localparam int PWT_TRIG_OUTPUTS = 4;

    ////////////////////////////////////////////////////////////////////////////
    // data widths
    localparam int PWT_POS_WIDTH = 32;
    localparam int PWT_ANG_WIDTH = 16;

    ////////////////////////////////////////////////////////////////////////////
    // angle scale: signed, full scale is half a revolution each way
    localparam logic signed [15:0] PWT_ANG_MIN = 16'sh8000;
    localparam logic signed [15:0] PWT_ANG_MAX = 16'sh7fff;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic PWT_TRIG_RST = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // source group selection per trigger output
    typedef enum logic {
        PWT_GRP_POS,
        PWT_GRP_ROT
    } pwt_group_t;

endpackage

/* File: pwt_window_triggers.sv */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// one window compare, shared by both channel groups
module pwt_win_cmp
    import pwt_pkg::*;
#(
    parameter int W = PWT_POS_WIDTH
)
(
    // compared value and edges
    input  wire logic signed [W-1:0] value,
    input  wire logic signed [W-1:0] left_edge,
    input  wire logic signed [W-1:0] right_edge,
    // profile
    input  wire logic                invert,
    // result
    output logic                     level
);

    logic below;
    logic above;

    ////////////////////////////////////////////////////////////////////////////
    // edges are inclusive; left above right gives an empty window
    always_comb
    begin
        below = (value < left_edge);
        above = (value > right_edge);
        if (below || above)
            level = invert;
        else
            level = ~invert;
    end

endmodule

////////////////////////////////////////////////////////////////////////////////
// one trigger output: OR of the selected sources of its own group
module pwt_out_route
    import pwt_pkg::*;
#(
    parameter int NPOS = PWT_POS_CHANNELS,
    parameter int NROT = PWT_ROT_CHANNELS
)
(
    // group choice
    input  wire logic            group_rot,
    // source selection
    input  wire logic [NPOS-1:0] pos_sel,
    input  wire logic [NROT-1:0] rot_sel,
    // source levels
    input  wire logic [NPOS-1:0] pos_lvl,
    input  wire logic [NROT-1:0] rot_lvl,
    // result
    output logic                 level
);

    logic pos_any;
    logic rot_any;

    ////////////////////////////////////////////////////////////////////////////
    // the unselected group is ignored, so groups never mix
    always_comb
    begin
        pos_any = |(pos_lvl & pos_sel);
        rot_any = |(rot_lvl & rot_sel);
        if (group_rot == 1'h1)
            level = rot_any;
        else
            level = pos_any;
    end

endmodule

////////////////////////////////////////////////////////////////////////////////
// position and rotor angle window triggers with output routing
module pwt_window_triggers
    import pwt_pkg::*;
#(
    parameter int NPOS = PWT_POS_CHANNELS,
    parameter int NROT = PWT_ROT_CHANNELS,
    parameter int NOUT = PWT_TRIG_OUTPUTS,
    parameter int PW   = PWT_POS_WIDTH,
    parameter int AW   = PWT_ANG_WIDTH
)
(
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire logic                       clk_en,
    // feedback
    input  wire logic signed [PW-1:0]       act_pos,
    input  wire logic signed [AW-1:0]       enc_angle,
    // position channel settings
    input  wire logic signed [NPOS*PW-1:0]  pos_left,
    input  wire logic signed [NPOS*PW-1:0]  pos_right,
    input  wire logic        [NPOS-1:0]     pos_invert,
    // rotor channel settings
    input  wire logic signed [NROT*AW-1:0]  rot_left,
    input  wire logic signed [NROT*AW-1:0]  rot_right,
    input  wire logic        [NROT-1:0]     rot_invert,
    // output routing
    input  wire logic        [NOUT-1:0]      out_group_rot,
    input  wire logic        [NOUT*NPOS-1:0] out_pos_sel,
    input  wire logic        [NOUT*NROT-1:0] out_rot_sel,
    // results
    output logic             [NPOS-1:0]      pos_trig,
    output logic             [NROT-1:0]      rot_trig,
    output logic             [NOUT-1:0]      trig_out
);

    ////////////////////////////////////////////////////////////////////////////
    // next levels, one bit per channel or output
    wire logic [NPOS-1:0] pos_trig_nxt;
    wire logic [NROT-1:0] rot_trig_nxt;
    wire logic [NOUT-1:0] trig_out_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // position channels: compare actual position only
    genvar gi;
    for (gi = 0; gi < NPOS; gi++)
    begin : g_pos
        pwt_win_cmp #(
            .W          (PW)
        ) u_cmp (
            .value      (act_pos),
            .left_edge  (pos_left[gi*PW +: PW]),
            .right_edge (pos_right[gi*PW +: PW]),
            .invert     (pos_invert[gi]),
            .level      (pos_trig_nxt[gi])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // rotor channels: signed angle, so the level repeats each turn
    genvar gj;
    for (gj = 0; gj < NROT; gj++)
    begin : g_rot
        pwt_win_cmp #(
            .W          (AW)
        ) u_cmp (
            .value      (enc_angle),
            .left_edge  (rot_left[gj*AW +: AW]),
            .right_edge (rot_right[gj*AW +: AW]),
            .invert     (rot_invert[gj]),
            .level      (rot_trig_nxt[gj])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // output routing, from the same sample as the channel levels
    genvar gk;
    for (gk = 0; gk < NOUT; gk++)
    begin : g_out
        pwt_out_route #(
            .NPOS      (NPOS),
            .NROT      (NROT)
        ) u_route (
            .group_rot (out_group_rot[gk]),
            .pos_sel   (out_pos_sel[gk*NPOS +: NPOS]),
            .rot_sel   (out_rot_sel[gk*NROT +: NROT]),
            .pos_lvl   (pos_trig_nxt),
            .rot_lvl   (rot_trig_nxt),
            .level     (trig_out_nxt[gk])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered channel and output levels
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            pos_trig <= {NPOS{PWT_TRIG_RST}};
        else if (clk_en)
            pos_trig <= pos_trig_nxt;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            rot_trig <= {NROT{PWT_TRIG_RST}};
        else if (clk_en)
            rot_trig <= rot_trig_nxt;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            trig_out <= {NOUT{PWT_TRIG_RST}};
        else if (clk_en)
            trig_out <= trig_out_nxt;
    end

endmodule

`default_nettype wire

/* File: pwt_window_triggers_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module pwt_chk (input wire logic core_clk, rst_n, clk_en, input wire logic signed [31:0] act_pos,
    input wire logic signed [127:0] pos_left, pos_right, input wire logic [15:0] out_pos_sel, out_rot_sel,
    input wire logic signed [15:0] enc_angle, input wire logic signed [63:0] rot_left, rot_right,
    input wire logic [3:0] pos_invert, rot_invert, out_group_rot, pos_trig, rot_trig, trig_out);
    wire logic pin = act_pos >= $signed(pos_left[31:0]) && act_pos <= $signed(pos_right[31:0]);
    wire logic rin = enc_angle >= $signed(rot_left[15:0]) && enc_angle <= $signed(rot_right[15:0]);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_po; clk_en && !pin |=> pos_trig[0] == $past(pos_invert[0]); endproperty
    a_po: assert property (p_po) else $error("pos outside");
    property p_pi; clk_en && pin |=> pos_trig[0] != $past(pos_invert[0]); endproperty
    a_pi: assert property (p_pi) else $error("pos inside");
    property p_or; clk_en && !out_group_rot[0] |=> trig_out[0] == |(pos_trig & $past(out_pos_sel[3:0])); endproperty
    a_or: assert property (p_or) else $error("or");
    property p_hold; !clk_en |=> $stable(trig_out); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_ro; clk_en && !rin |=> rot_trig[0] == $past(rot_invert[0]); endproperty
    a_ro: assert property (p_ro) else $error("rot outside");
    property p_ri; clk_en && rin |=> rot_trig[0] != $past(rot_invert[0]); endproperty
    a_ri: assert property (p_ri) else $error("rot inside");
    property p_ror; clk_en && out_group_rot[1] |=> trig_out[1] == |(rot_trig & $past(out_rot_sel[7:4])); endproperty
    a_ror: assert property (p_ror) else $error("rot or");
endmodule
bind pwt_window_triggers pwt_chk u_chk (.*);
`default_nettype wire

/* File: pwt_feedback_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pwt_feedback_model (input wire logic core_clk, input wire logic signed [31:0] pos_cmd,
    input wire logic signed [15:0] ang_cmd, output var logic signed [31:0] act_pos,
    output var logic signed [15:0] enc_angle);
    always @(posedge core_clk) {act_pos, enc_angle} <= #1 {pos_cmd, ang_cmd};
endmodule
`default_nettype wire

/* File: tb_pwt_window_triggers.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_pwt_window_triggers;
    logic               core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, e;
    logic signed [31:0] pos_cmd = '0, act_pos;
    logic signed [15:0] ang_cmd = '0, enc_angle;
    logic [127:0]       pos_left = {4{32'hffffff9c}}, pos_right = {4{32'h64}};
    logic [63:0]        rot_left = {4{16'hff9c}}, rot_right = {4{16'h64}};
    logic [15:0]        out_pos_sel = '1, out_rot_sel = '1;
    logic [3:0]         pos_invert = '0, rot_invert = '0, out_group_rot = 4'ha, pos_trig, rot_trig, trig_out;
    int                 fail_count = 0, samples_checked = 0, cycles = 0;
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) if (++cycles > 200) summarize;
    pwt_feedback_model u_fb (.core_clk(core_clk), .pos_cmd(pos_cmd), .ang_cmd(ang_cmd), .act_pos(act_pos),
        .enc_angle(enc_angle));
    pwt_window_triggers DUT (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .act_pos(act_pos),
        .enc_angle(enc_angle), .pos_left(pos_left), .pos_right(pos_right), .pos_invert(pos_invert),
        .rot_left(rot_left), .rot_right(rot_right), .rot_invert(rot_invert), .out_group_rot(out_group_rot),
        .out_pos_sel(out_pos_sel), .out_rot_sel(out_rot_sel), .pos_trig(pos_trig), .rot_trig(rot_trig),
        .trig_out(trig_out));
    task automatic chk(input string name, input logic [7:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic route_select;
        pos_cmd = '0;
        ang_cmd = '0;
        pos_invert = 4'h5;
        rot_invert = 4'h3;
        out_pos_sel = 16'hf2f1;
        out_rot_sel = 16'h8f1f;
        #12 chk("chan", {pos_trig, rot_trig}, 8'hac);
        chk("route", {4'h0, trig_out}, 8'h0c);
        out_pos_sel = '1;
        out_rot_sel = '1;
    endtask
    task automatic extremes;
        pos_invert = '0;
        rot_invert = '0;
        rot_left = {16'h8000, 16'h8000, 16'h8000, 16'h7fff};
        rot_right = {4{16'h7fff}};
        ang_cmd = 16'h8000;
        #12 chk("rot_min", {4'h0, rot_trig}, 8'h0e);
        ang_cmd = 16'h7fff;
        #12 chk("rot_max", {4'h0, rot_trig}, 8'h0f);
    endtask
    task automatic freeze;
        clk_en = 1'b0;
        pos_cmd = 32'h3e8;
        ang_cmd = 16'h8000;
        #12 chk("freeze", {pos_trig, rot_trig}, 8'hff);
        chk("freeze_out", {4'h0, trig_out}, 8'h0f);
        clk_en = 1'b1;
        #12 chk("thaw", {pos_trig, rot_trig}, 8'h0e);
        chk("thaw_out", {4'h0, trig_out}, 8'h0a);
    endtask
    task automatic reset_midrun;
        rst_n = 1'b0;
        #8 chk("reset", {pos_trig, rot_trig}, 8'h00);
        chk("reset_out", {4'h0, trig_out}, 8'h00);
        rst_n = 1'b1;
        #12 chk("rerun", {pos_trig, rot_trig}, 8'h0e);
        chk("rerun_out", {4'h0, trig_out}, 8'h0a);
    endtask
    task automatic window_sweep;
        for (int i = 0; i < 8; i++)
        begin
            e = ^i[2:0];
            {rot_invert, pos_invert} = {{4{~i[2]}}, {4{i[2]}}};
            ang_cmd = i[1] ? 16'h64 + i[0] : 16'hff9b + i[0];
            pos_cmd = ang_cmd;
            #12 chk("sweep", {pos_trig, rot_trig}, {{4{e}}, {4{!e}}});
            chk("sweep_out", {4'h0, trig_out}, {4'h0, !e, e, !e, e});
        end
    endtask
    task automatic summarize;
        fail_count += int'(cycles > 200);
        if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #19 rst_n = 1'b1;
        window_sweep;
        route_select;
        extremes;
        freeze;
        reset_midrun;
        summarize;
    end
endmodule
`default_nettype wire
